// ### rtl/adc_i2c_pkg.sv
package adc_i2c_pkg;

    localparam int REF_CLK_KHZ   = 200000;
    localparam int MOD_NORMAL_KHZ = 256;
    localparam int MOD_TURBO_KHZ  = 512;
    localparam logic [9:0] MOD_DIV_NORMAL = 10'(REF_CLK_KHZ / MOD_NORMAL_KHZ);
    localparam logic [9:0] MOD_DIV_TURBO  = 10'(REF_CLK_KHZ / MOD_TURBO_KHZ);

    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [7:0] GC_RESET_BYTE     = 8'h06;

    localparam logic [6:0] RESET_OPCODE = 7'h03;
    localparam logic [6:0] START_OPCODE = 7'h04;
    localparam logic [6:0] SLEEP_OPCODE = 7'h01;
    localparam logic [3:0] RDATA_NIBBLE = 4'h1;
    localparam logic [3:0] CONFIG_READ_CMD_NIBBLE  = 4'h2;
    localparam logic [3:0] CONFIG_WRITE_CMD_NIBBLE  = 4'h4;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] CFG_RESET     = 8'h00;

    localparam logic signed [23:0] RAW_MAX    = 24'sh007FFF;
    localparam logic signed [23:0] RAW_MIN    = -24'sh008000;
    localparam logic [15:0]        RESULT_MAX = 16'h7FFF;
    localparam logic [15:0]        RESULT_MIN = 16'h8000;

    localparam logic [3:0] READY_RELEASE_PULSE_WIDTH = 4'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
    } bus_state_e;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_RESET, CMD_START, CMD_SLEEP, CMD_RDATA, CMD_CONFIG_READ_CMD, CMD_CONFIG_WRITE_CMD
    } cmd_e;

    function automatic cmd_e decode_cmd(input logic [7:0] b);
        cmd_e c;
        c = CMD_NONE;
        if (b[7:1] == RESET_OPCODE) c = CMD_RESET;
        else if (b[7:1] == START_OPCODE) c = CMD_START;
        else if (b[7:1] == SLEEP_OPCODE) c = CMD_SLEEP;
        else if (b[7:4] == RDATA_NIBBLE) c = CMD_RDATA;
        else if (b[7:4] == CONFIG_READ_CMD_NIBBLE) c = CMD_CONFIG_READ_CMD;
        else if (b[7:4] == CONFIG_WRITE_CMD_NIBBLE) c = CMD_CONFIG_WRITE_CMD;
        return c;
    endfunction

    // Raw value is in code steps; clipping keeps out-of-range inputs from wrapping.
    function automatic logic [15:0] sat16(input logic signed [23:0] raw);
        logic [15:0] v;
        v = raw[15:0];
        if (raw > RAW_MAX) v = RESULT_MAX;
        else if (raw < RAW_MIN) v = RESULT_MIN;
        return v;
    endfunction

endpackage

// ### rtl/result_if.sv
interface result_if;
    logic [15:0] result;
    logic        ready;
    logic        latch;
    logic        modTick;

    modport producer (
        output result,
        output ready,
        input  latch,
        input  modTick
    );

    modport consumer (
        input  result,
        input  ready,
        output latch,
        output modTick
    );
endinterface

// ### rtl/conversion_ready_tracker.sv
module conversion_ready_tracker
    import adc_i2c_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               convDone,
    input  wire logic signed [23:0] convRaw,
    result_if.producer              rif
);
    typedef struct packed {
        logic [15:0] result;
        logic [15:0] stash;
        logic        ready;
        logic        releasing;
        logic [3:0]  relCnt;
    } trk_s;

    trk_s r;
    trk_s next_r;

    always_comb begin
        next_r = r;
        if (rif.latch) begin
            next_r.ready = 1'b0;
        end
        if (r.releasing && rif.modTick) begin
            next_r.relCnt = 4'(r.relCnt + 4'h1);
            if (r.relCnt == READY_RELEASE_PULSE_WIDTH - 4'h1) begin
                next_r.result    = r.stash;
                next_r.ready     = 1'b1;
                next_r.releasing = 1'b0;
            end
        end
        // A completion in the same cycle as a latch still raises the flag.
        if (convDone) begin
            if (r.ready && !rif.latch) begin
                next_r.stash     = sat16(convRaw);
                next_r.ready     = 1'b0;
                next_r.releasing = 1'b1;
                next_r.relCnt    = 4'h0;
            end else begin
                next_r.result    = sat16(convRaw);
                next_r.ready     = 1'b1;
                next_r.releasing = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rif.result = r.result;
    assign rif.ready  = r.ready;
endmodule

// ### rtl/adc_i2c_target.sv
module adc_i2c_target
    import adc_i2c_pkg::*;
#(
    parameter int TIMEOUT_NORMAL_MOD = 14000,
    parameter int TIMEOUT_TURBO_MOD  = 28000
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               sclIn,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaOe,
    output logic                    conversionReadyOut_n,
    output logic                    conversionReadyOe,
    input  wire logic [6:0]         targetAddr,
    input  wire logic               turboMode,
    input  wire logic               convDone,
    input  wire logic signed [23:0] convRaw,
    output logic                    resetCmd,
    output logic                    startCmd,
    output logic                    sleepCmd,
    output logic                    configWrite,
    output logic [31:0]             configRegs
);
    typedef struct packed {
        bus_state_e     st;
        logic [1:0]     sclSh;
        logic           sclPrev;
        logic [1:0]     sdaSh;
        logic           sdaPrev;
        logic [3:0]     bitCnt;
        logic [7:0]     shiftIn;
        logic [15:0]    txWord;
        logic           isRead;
        logic           gcMode;
        logic           wregPending;
        logic [1:0]     regAddr;
        logic [3:0][7:0] cfg;
        logic           sdaLow;
        logic           resetPulse;
        logic           startPulse;
        logic           sleepPulse;
        logic           latchPulse;
        logic           cfgWrPulse;
        logic [9:0]     modDiv;
        logic           modTick;
        logic [14:0]    idleCnt;
        logic           busy;
    } core_s;

    core_s r;
    core_s next_r;

    result_if rif ();

    conversion_ready_tracker u_ready (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .convDone (convDone),
        .convRaw  (convRaw),
        .rif      (rif.producer)
    );

    logic       scl;
    logic       sda;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       timeout;
    logic [9:0] divLimit;
    logic [14:0] idleLimit;
    logic [7:0] rxByte;
    cmd_e       cmd;

    always_comb begin
        next_r = r;
        next_r.resetPulse = 1'b0;
        next_r.startPulse = 1'b0;
        next_r.sleepPulse = 1'b0;
        next_r.latchPulse = 1'b0;
        next_r.cfgWrPulse = 1'b0;
        next_r.modTick    = 1'b0;

        // Two-stage synchronisers; only the second stage feeds logic.
        // The 5 ns sampling clock resolves edges at up to 1 Mbit/s.
        next_r.sclSh   = {r.sclSh[0], sclIn};
        next_r.sdaSh   = {r.sdaSh[0], sdaIn};
        scl            = r.sclSh[1];
        sda            = r.sdaSh[1];
        next_r.sclPrev = scl;
        next_r.sdaPrev = sda;
        sclRise   = scl && !r.sclPrev;
        sclFall   = !scl && r.sclPrev;
        startCond = scl && r.sclPrev && !sda && r.sdaPrev;
        stopCond  = scl && r.sclPrev && sda && !r.sdaPrev;

        // Modulator tick: the rate doubles in turbo mode.
        divLimit = turboMode ? MOD_DIV_TURBO : MOD_DIV_NORMAL;
        if (r.modDiv >= divLimit - 10'h001) begin
            next_r.modDiv  = 10'h000;
            next_r.modTick = 1'b1;
        end else begin
            next_r.modDiv = 10'(r.modDiv + 10'h001);
        end

        // Idle time counts only while a transaction is open.
        idleLimit = turboMode ? 15'(TIMEOUT_TURBO_MOD) : 15'(TIMEOUT_NORMAL_MOD);
        if (!r.busy || sclRise || sclFall || startCond) begin
            next_r.idleCnt = 15'h0000;
        end else if (r.modTick && r.idleCnt != 15'h7FFF) begin
            next_r.idleCnt = 15'(r.idleCnt + 15'h0001);
        end
        timeout = r.busy && (r.idleCnt >= idleLimit);

        rxByte = r.shiftIn;
        cmd    = decode_cmd(rxByte);

        if (timeout) begin
            // The controller is expected to start over with a fresh START.
            next_r.st          = ST_IDLE;
            next_r.busy        = 1'b0;
            next_r.sdaLow      = 1'b0;
            next_r.gcMode      = 1'b0;
            next_r.wregPending = 1'b0;
        end else if (startCond) begin
            // A repeated START also ends any ignore phase.
            next_r.st          = ST_ADDR;
            next_r.bitCnt      = 4'h0;
            next_r.busy        = 1'b1;
            next_r.sdaLow      = 1'b0;
            next_r.gcMode      = 1'b0;
            next_r.wregPending = 1'b0;
        end else if (stopCond) begin
            next_r.st          = ST_IDLE;
            next_r.busy        = 1'b0;
            next_r.sdaLow      = 1'b0;
            next_r.gcMode      = 1'b0;
            next_r.wregPending = 1'b0;
        end else begin
            unique case (r.st)
                ST_IDLE, ST_IGNORE: begin
                    next_r.sdaLow = 1'b0;
                end
                ST_ADDR: begin
                    if (sclRise) begin
                        next_r.shiftIn = {r.shiftIn[6:0], sda};
                        next_r.bitCnt  = 4'(r.bitCnt + 4'h1);
                    end else if (sclFall && r.bitCnt == BITS_PER_BYTE) begin
                        if (r.shiftIn[7:1] == targetAddr) begin
                            next_r.sdaLow = 1'b1;
                            next_r.st     = ST_ADDR_ACK;
                            next_r.isRead = r.shiftIn[0];
                        end else if (r.shiftIn[7:1] == GENERAL_CALL_ADDR && !r.shiftIn[0]) begin
                            next_r.sdaLow = 1'b1;
                            next_r.st     = ST_ADDR_ACK;
                            next_r.isRead = 1'b0;
                            next_r.gcMode = 1'b1;
                        end else begin
                            next_r.st = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK: begin
                    if (r.st == ST_RD_ACK && sclRise && sda) begin
                        next_r.st = ST_IGNORE;
                    end else if (sclFall) begin
                        if (r.isRead) begin
                            // Word rotates so repeated reads return it again.
                            next_r.st     = ST_RD_BYTE;
                            next_r.sdaLow = !r.txWord[15];
                            next_r.txWord = {r.txWord[14:0], r.txWord[15]};
                            next_r.bitCnt = 4'h1;
                        end else begin
                            next_r.st     = ST_WR_BYTE;
                            next_r.sdaLow = 1'b0;
                            next_r.bitCnt = 4'h0;
                        end
                    end
                end
                ST_RD_BYTE: begin
                    if (sclFall) begin
                        if (r.bitCnt == BITS_PER_BYTE) begin
                            next_r.sdaLow = 1'b0;
                            next_r.st     = ST_RD_ACK;
                        end else begin
                            next_r.sdaLow = !r.txWord[15];
                            next_r.txWord = {r.txWord[14:0], r.txWord[15]};
                            next_r.bitCnt = 4'(r.bitCnt + 4'h1);
                        end
                    end
                end
                ST_WR_BYTE: begin
                    if (sclRise) begin
                        next_r.shiftIn = {r.shiftIn[6:0], sda};
                        next_r.bitCnt  = 4'(r.bitCnt + 4'h1);
                    end else if (sclFall && r.bitCnt == BITS_PER_BYTE) begin
                        next_r.sdaLow = 1'b1;
                        next_r.st     = ST_WR_ACK;
                        // Byte is acted on at the eighth falling edge.
                        if (r.gcMode) begin
                            next_r.gcMode = 1'b0;
                            if (rxByte == GC_RESET_BYTE) begin
                                next_r.resetPulse = 1'b1;
                                next_r.cfg        = {4{CFG_RESET}};
                            end
                        end else if (r.wregPending) begin
                            next_r.wregPending      = 1'b0;
                            next_r.cfg[r.regAddr]   = rxByte;
                            next_r.cfgWrPulse       = 1'b1;
                        end else begin
                            unique case (cmd)
                                CMD_RESET: begin
                                    next_r.resetPulse = 1'b1;
                                    next_r.cfg        = {4{CFG_RESET}};
                                end
                                CMD_START: next_r.startPulse = 1'b1;
                                CMD_SLEEP: next_r.sleepPulse = 1'b1;
                                CMD_RDATA: begin
                                    next_r.txWord     = rif.result;
                                    next_r.latchPulse = 1'b1;
                                end
                                CMD_CONFIG_READ_CMD: begin
                                    next_r.txWord = {2{r.cfg[rxByte[3:2]]}};
                                end
                                CMD_CONFIG_WRITE_CMD: begin
                                    next_r.wregPending = 1'b1;
                                    next_r.regAddr     = rxByte[3:2];
                                end
                                CMD_NONE: begin
                                end
                            endcase
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (sclFall) begin
                        next_r.sdaLow = 1'b0;
                        next_r.bitCnt = 4'h0;
                        next_r.st     = ST_WR_BYTE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rif.latch   = r.latchPulse;
    assign rif.modTick = r.modTick;

    // Both pins are open drain: the data value is always low.
    assign sdaOut               = 1'b0;
    assign sdaOe                = r.sdaLow;
    assign conversionReadyOut_n = 1'b0;
    assign conversionReadyOe    = rif.ready;
    assign resetCmd             = r.resetPulse;
    assign startCmd             = r.startPulse;
    assign sleepCmd             = r.sleepPulse;
    assign configWrite          = r.cfgWrPulse;
    assign configRegs           = r.cfg;
endmodule

// ### testbench/adc_i2c_target_properties.sv
module adc_i2c_target_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        sclIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic        conversionReadyOut_n,
    input wire logic        conversionReadyOe,
    input wire logic        convDone,
    input wire logic        resetCmd,
    input wire logic        startCmd,
    input wire logic        sleepCmd,
    input wire logic        configWrite,
    input wire logic [31:0] configRegs
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_unread;
        convDone && conversionReadyOe ##1 !conversionReadyOe;
    endsequence

    a_ready_pin_low: assert property (conversionReadyOut_n == 1'b0)
        else $error("ready pin level is not low");
    a_data_pin_low: assert property (sdaOut == 1'b0)
        else $error("data pin level is not low");
    a_ready_set: assert property (convDone && !conversionReadyOe |=> conversionReadyOe)
        else $error("ready not set after result");
    a_ready_unread: assert property (convDone && conversionReadyOe |=> !conversionReadyOe)
        else $error("unread ready not released");
    a_ready_gap: assert property (s_unread |=> !conversionReadyOe [*8])
        else $error("ready release pulse too short");
    a_ready_clear: assert property ($fell(conversionReadyOe) |-> $past(convDone) || !sclIn)
        else $error("ready released outside a latch");
    a_sda_steady: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data drive changed while clock high");
    a_cmd_single: assert property ($onehot0({resetCmd, startCmd, sleepCmd, configWrite}))
        else $error("several command pulses at once");
    a_cmd_pulse: assert property (resetCmd || startCmd || sleepCmd |=> !(resetCmd || startCmd || sleepCmd))
        else $error("command pulse longer than one cycle");
    a_reset_clears: assert property (resetCmd |-> ##[0:2] configRegs == 32'h0)
        else $error("reset command left configuration set");
endmodule

// ### testbench/i2c_controller_model.sv
module i2c_controller_model (
    output logic      scl,
    output logic      sda,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5ns;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Works from idle and mid-frame alike; SCL is left low.
    task automatic start();
        sda = 1'b1;
        #(HALF);
        scl = 1'b1;
        #(HALF);
        sda = 1'b0;
        #(HALF);
        scl = 1'b0;
        #(HALF / 4);
    endtask
    // The clock then stands high until the next frame.
    task automatic stop();
        sda = 1'b0;
        #(HALF);
        scl = 1'b1;
        #(HALF);
        sda = 1'b1;
        #(2 * HALF);
    endtask
    // SDA moves a quarter phase after SCL falls, so the target never sees it cross a high clock.
    task automatic bit1(input logic b, output logic r);
        sda = b;
        #(HALF);
        scl = 1'b1;
        #(HALF / 2);
        r = sdaLine;
        #(HALF / 2);
        scl = 1'b0;
        #(HALF / 4);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
        bit1(ackIn, ack);
    endtask
endmodule

// ### testbench/tb_adc_i2c_target.sv
module tb_adc_i2c_target
    import adc_i2c_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO_N = 20;
    localparam int TO_T = 40;
    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               turboMode = 1'b0;
    logic               convDone = 1'b0;
    logic signed [23:0] convRaw = 24'h0;
    logic [6:0]         targetAddr = 7'h40;
    logic               ctlScl, ctlSda, sdaOut, sdaOe, conversionReadyOut_n, conversionReadyOe;
    logic               resetCmd, startCmd, sleepCmd, configWrite;
    logic [31:0]        configRegs;
    wire logic          sdaIn = ctlSda & ~sdaOe;
    wire logic [3:0]    pulses = {configWrite, sleepCmd, startCmd, resetCmd};
    int                 fail_count = 0;
    int                 checks_done = 0;
    int                 pc[4] = '{0, 0, 0, 0};
    int                 ep[4] = '{0, 0, 0, 0};
    int                 cfg[4] = '{0, 0, 0, 0};
    logic [7:0]         q[$];

    adc_i2c_target #(.TIMEOUT_NORMAL_MOD(TO_N), .TIMEOUT_TURBO_MOD(TO_T)) i_adc_i2c_target (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(ctlScl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .conversionReadyOut_n(conversionReadyOut_n), .conversionReadyOe(conversionReadyOe),
        .targetAddr(targetAddr), .turboMode(turboMode), .convDone(convDone), .convRaw(convRaw),
        .resetCmd(resetCmd), .startCmd(startCmd), .sleepCmd(sleepCmd), .configWrite(configWrite),
        .configRegs(configRegs));
    i2c_controller_model ctl (.scl(ctlScl), .sda(ctlSda), .sdaLine(sdaIn));

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        foreach (pc[j]) pc[j] += int'(pulses[j] === 1'b1);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic sendW(input logic [6:0] a, input logic [7:0] d[$]);
        logic [7:0] r;
        logic       k;
        ctl.start();
        ctl.xfer({a, 1'b0}, 1'b1, r, k);
        check("addrAck", k, 1'b0);
        foreach (d[i]) begin
            ctl.xfer(d[i], 1'b1, r, k);
            check("byteAck", k, 1'b0);
        end
        ctl.stop();
    endtask
    task automatic readN(input int n);
        logic [7:0] r;
        logic       k;
        ctl.start();
        ctl.xfer({targetAddr, 1'b1}, 1'b1, r, k);
        check("readAck", k, 1'b0);
        for (int i = 0; i < n; i++) begin
            ctl.xfer(8'hFF, 1'(i == n - 1), r, k);
            check("readByte", r, q.pop_front());
        end
        ctl.stop();
    endtask
    task automatic conv(input int raw);
        @(posedge ref_clk);
        convDone <= 1'b1;
        convRaw <= 24'(raw);
        @(posedge ref_clk);
        convDone <= 1'b0;
        @(posedge ref_clk);
    endtask
    function automatic logic [15:0] clip(input int raw);
        return 16'(raw > 32'sh7FFF ? 32'sh7FFF : raw < -32'sh8000 ? -32'sh8000 : raw);
    endfunction

    initial begin
        logic [7:0]  r;
        logic        k;
        logic [7:0]  cmds[4];
        logic [15:0] e;
        int          raws[8];
        int          n;
        void'($urandom(32'hD80564C6));
        @(posedge ref_clk);
        targetAddr <= 7'h40 | 7'($urandom_range(15));
        idle(5);
        rst_n <= 1'b1;
        idle(5);
        check("resetRegs", configRegs, 32'h0);
        check("pinLevels", {sdaOut, conversionReadyOut_n}, 2'b00);
        // A refused frame must not act on the reset byte that follows.
        ctl.start();
        ctl.xfer({targetAddr ^ 7'h01, 1'b0}, 1'b1, r, k);
        check("nackAddr", k, 1'b1);
        ctl.xfer({RESET_OPCODE, 1'b0}, 1'b1, r, k);
        check("nackData", k, 1'b1);
        ctl.stop();
        check("nackPulse", 32'(pc[0]), 32'h0);
        $display("Test refusal done");
        cmds = '{{RESET_OPCODE, 1'($urandom)}, {START_OPCODE, 1'($urandom)}, {SLEEP_OPCODE, 1'($urandom)}, 8'hF0};
        for (int c = 0; c < 4; c++) begin
            sendW(targetAddr, '{cmds[c]});
            if (c < 3) ep[c]++;
            foreach (pc[j]) check("cmdPulses", 32'(pc[j]), 32'(ep[j]));
        end
        $display("Test commands done");
        for (int a = 0; a < 4; a++) begin
            cfg[a] = int'($urandom_range(255));
            sendW(targetAddr, '{{CONFIG_WRITE_CMD_NIBBLE, 2'(a), 2'($urandom)}, 8'(cfg[a])});
            ep[3]++;
            check("cfgWrites", 32'(pc[3]), 32'(ep[3]));
            check("cfgRegs", configRegs, {8'(cfg[3]), 8'(cfg[2]), 8'(cfg[1]), 8'(cfg[0])});
        end
        for (int a = 0; a < 4; a++) begin
            sendW(targetAddr, '{{CONFIG_READ_CMD_NIBBLE, 2'(a), 2'($urandom)}});
            q = '{8'(cfg[a]), 8'(cfg[a])};
            readN(2);
        end
        $display("Test configuration done");
        raws = '{1, 0, -1, 32'sh7FFF, 32'sh9000, -32'sh8000, -32'sh9000, 0};
        raws[7] = int'($urandom_range(32'h1FFFF)) - 32'sh10000;
        foreach (raws[i]) begin
            conv(int'($urandom_range(32'hFF)));
            check("readySet", conversionReadyOe, 1'b1);
            conv(raws[i]);
            idle(3 * int'(MOD_DIV_NORMAL));
            check("readyAgain", conversionReadyOe, 1'b1);
            sendW(targetAddr, '{{RDATA_NIBBLE, 4'($urandom)}});
            check("readyClear", conversionReadyOe, 1'b0);
            e = clip(raws[i]);
            q = '{e[15:8], e[7:0], e[15:8]};
            readN(3);
        end
        $display("Test results done");
        sendW(targetAddr, '{{CONFIG_WRITE_CMD_NIBBLE, 4'h8}, 8'hA5});
        sendW(GENERAL_CALL_ADDR, '{GC_RESET_BYTE});
        idle(4);
        check("gcReset", configRegs, 32'h0);
        $display("Test general call done");
        turboMode <= 1'b1;
        ctl.start();
        ctl.xfer({targetAddr, 1'b0}, 1'b1, r, k);
        for (int i = 0; i < 8; i++) ctl.bit1(1'b0, k);
        idle(4);
        check("ackHeld", sdaOe, 1'b1);
        n = 0;
        while (sdaOe === 1'b1 && n < (TO_T + 2) * int'(MOD_DIV_TURBO)) begin
            @(posedge ref_clk);
            n++;
        end
        check("timeoutSpan", 32'(n >= (TO_T - 1) * int'(MOD_DIV_TURBO) - 100 && n <= (TO_T + 1) * int'(MOD_DIV_TURBO)), 32'h1);
        if (sdaOe !== 1'b0) stop_test();
        sendW(targetAddr, '{{CONFIG_WRITE_CMD_NIBBLE, 4'h4}, 8'h5A});
        check("afterTimeout", configRegs[15:8], 8'h5A);
        $display("Test timeout done");
        stop_test();
    end
endmodule

bind adc_i2c_target adc_i2c_target_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .conversionReadyOut_n(conversionReadyOut_n), .conversionReadyOe(conversionReadyOe),
    .convDone(convDone), .resetCmd(resetCmd), .startCmd(startCmd), .sleepCmd(sleepCmd),
    .configWrite(configWrite), .configRegs(configRegs));
